// ==== rtl/crs_pkg.sv ====
// package: constants for the core register set
package crs_pkg;

	// ***********************************************
	// register space and flag layout
	// ***********************************************
	localparam logic [7:0] CRS_FLAGS_ADDR = 8'hf7;
	localparam logic [7:0] CRS_FLAGS_RESET = 8'h02;
	localparam int CRS_FLAG_GIE = 0;
	localparam int CRS_FLAG_ZERO = 1;
	localparam int CRS_FLAG_CARRY = 2;
	localparam int CRS_FLAG_SUPER = 3;
	localparam int CRS_FLAG_BANK = 4;
	// bits of the flags register that OR/AND may alter (super excluded)
	localparam logic [7:0] CRS_FLAGS_USER_MASK = 8'h17;
	localparam logic [7:0] CRS_FLAGS_IMPL_MASK = 8'h1f;
	localparam logic [7:0] CRS_ZERO_BYTE = 8'h00;
	localparam logic [15:0] CRS_PC_RESET = 16'h0000;

	// ***********************************************
	// operation codes driven by the execution logic
	// ***********************************************
	typedef enum logic [3:0] {
		CRS_OP_NONE = 4'b0000,
		CRS_OP_ADD = 4'b0001,
		CRS_OP_ADC = 4'b0010,
		CRS_OP_SUB = 4'b0011,
		CRS_OP_AND = 4'b0100,
		CRS_OP_OR = 4'b0101,
		CRS_OP_XOR = 4'b0110,
		CRS_OP_SHL = 4'b0111,
		CRS_OP_SHR = 4'b1000,
		CRS_OP_MOV = 4'b1001,
		CRS_OP_SWAP = 4'b1010
	} crs_op_t;

	// destination selector
	typedef enum logic [2:0] {
		CRS_DST_NONE = 3'b000,
		CRS_DST_ACC = 3'b001,
		CRS_DST_INDEX = 3'b010,
		CRS_DST_SP = 3'b011,
		CRS_DST_FLAGS = 3'b100
	} crs_dst_t;

	// stack pointer actions
	typedef enum logic [2:0] {
		CRS_SP_HOLD = 3'b000,
		CRS_SP_PUSH1 = 3'b001,
		CRS_SP_POP1 = 3'b010,
		CRS_SP_PUSH2 = 3'b011,
		CRS_SP_POP2 = 3'b100,
		CRS_SP_POP3 = 3'b101
	} crs_spop_t;

endpackage : crs_pkg

// ==== rtl/crs_alu.sv ====
// module: combinational arithmetic/logic unit with carry out and a carry-valid flag
module crs_alu (
	input wire logic [3:0] i_op,
	input wire logic [7:0] i_a,
	input wire logic [7:0] i_b,
	input wire logic i_carry,
	output logic [7:0] o_result,
	output logic o_carry,
	output logic o_carry_valid
);

	logic [8:0] wide;

	always_comb begin
		wide = {1'b0, i_a};
		o_carry_valid = 1'b1;
		case (crs_pkg::crs_op_t'(i_op))
			crs_pkg::CRS_OP_ADD: begin
				wide = {1'b0, i_a} + {1'b0, i_b};
			end
			crs_pkg::CRS_OP_ADC: begin
				wide = {1'b0, i_a} + {1'b0, i_b} + {8'h00, i_carry};
			end
			crs_pkg::CRS_OP_SUB: begin
				wide = {1'b0, i_a} - {1'b0, i_b};
			end
			crs_pkg::CRS_OP_AND: begin
				wide = {1'b0, i_a & i_b};
				o_carry_valid = 1'b0;
			end
			crs_pkg::CRS_OP_OR: begin
				wide = {1'b0, i_a | i_b};
				o_carry_valid = 1'b0;
			end
			crs_pkg::CRS_OP_XOR: begin
				wide = {1'b0, i_a ^ i_b};
				o_carry_valid = 1'b0;
			end
			crs_pkg::CRS_OP_SHL: begin
				wide = {i_a, 1'b0};
			end
			crs_pkg::CRS_OP_SHR: begin
				wide = {i_a[0], 1'b0, i_a[7:1]};
			end
			crs_pkg::CRS_OP_MOV: begin
				wide = {1'b0, i_b};
				o_carry_valid = 1'b0;
			end
			default: begin
				wide = {1'b0, i_a};
				o_carry_valid = 1'b0;
			end
		endcase
		o_result = wide[7:0];
		o_carry = wide[8];
	end

endmodule : crs_alu

// ==== rtl/crs_core_regs.sv ====
// module: architectural register set of the 8-bit core
// Behaviour
// - the program counter is 16 bits and reaches all of program memory directly.
// - the accumulator receives the result of source-addressed instructions.
// - the index register supplies the offset added to form indexed addresses.
// - the stack pointer tracks top of stack and moves on push, pop, calls and returns.
// - swap and add instructions may also write the stack pointer.
// - the flags keep zero at bit 1, carry at bit 2 and supervisory state at bit 3.
// - flags bit 0 is the global interrupt enable.
// - user code cannot alter the supervisory bit; only the core changes it.
// - arithmetic, logic and shift operations update flags as each operation dictates.
// - core registers change only through instruction execution, not as register-space cells.
// - the flags register reads at register address f7 and resets to 0x02.
// - flags bit 4 selects register bank 0 or bank 1.
// - software sets or clears flag bits only via OR and AND targeting the flags.
module crs_core_regs (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_clk_en,
	// execution request
	input wire logic i_exec,
	input wire logic [3:0] i_op,
	input wire logic [2:0] i_dst,
	input wire logic [7:0] i_operand,
	input wire logic i_operand_is_index,
	input wire logic i_set_flags,
	// program counter control
	input wire logic i_pc_load,
	input wire logic [15:0] i_pc_target,
	input wire logic i_pc_inc,
	input wire logic [1:0] i_pc_step,
	// stack control
	input wire logic [2:0] i_sp_op,
	// supervisory entry/exit by the core
	input wire logic i_super_enter,
	input wire logic i_super_leave,
	// interrupt entry clears the global enable
	input wire logic i_int_entry,
	// register-space read port for the flags
	input wire logic i_rd_en,
	input wire logic [7:0] i_rd_addr,
	output logic [7:0] o_rd_data,
	output logic o_rd_hit,
	// state views for the execution logic
	output logic [15:0] o_program_counter,
	output logic [7:0] o_program_counter_low,
	output logic [7:0] o_program_counter_high,
	output logic [7:0] o_accumulator,
	output logic [7:0] o_index,
	output logic [7:0] o_stack_pointer,
	output logic [7:0] o_processor_flags,
	output logic [7:0] o_indexed_addr,
	output logic o_global_interrupt_enable,
	output logic o_bank_select,
	output logic o_supervisor
);

	// ***********************************************
	// state
	// ***********************************************
	logic [15:0] pc_q;
	logic [15:0] pc_d;
	logic [7:0] acc_q;
	logic [7:0] acc_d;
	logic [7:0] idx_q;
	logic [7:0] idx_d;
	logic [7:0] sp_q;
	logic [7:0] sp_d;
	logic [7:0] flags_q;
	logic [7:0] flags_d;
	logic [7:0] rd_data_q;
	logic rd_hit_q;

	logic [7:0] alu_a;
	logic [7:0] alu_b;
	logic [7:0] alu_res;
	logic alu_carry;
	logic alu_carry_valid;
	logic [7:0] swap_partner;
	logic dst_acc;
	logic dst_idx;
	logic dst_sp;
	logic dst_flags;
	logic is_swap;
	logic rd_match;
	logic flags_logic_wr;
	logic [7:0] flags_sw;
	logic [15:0] pc_seq;

	assign dst_acc = i_exec && (crs_pkg::crs_dst_t'(i_dst) == crs_pkg::CRS_DST_ACC);
	assign dst_idx = i_exec && (crs_pkg::crs_dst_t'(i_dst) == crs_pkg::CRS_DST_INDEX);
	assign dst_sp = i_exec && (crs_pkg::crs_dst_t'(i_dst) == crs_pkg::CRS_DST_SP);
	assign dst_flags = i_exec && (crs_pkg::crs_dst_t'(i_dst) == crs_pkg::CRS_DST_FLAGS);
	assign is_swap = (crs_pkg::crs_op_t'(i_op) == crs_pkg::CRS_OP_SWAP);
	// only OR and AND may write the flags from software
	assign flags_logic_wr = dst_flags && ((crs_pkg::crs_op_t'(i_op) == crs_pkg::CRS_OP_OR) ||
		(crs_pkg::crs_op_t'(i_op) == crs_pkg::CRS_OP_AND));
	// the flags are the only core register that the register space decodes
	assign rd_match = i_rd_en && (i_rd_addr == crs_pkg::CRS_FLAGS_ADDR);

	// ***********************************************
	// operand selection and alu
	// ***********************************************
	always_comb begin
		case (crs_pkg::crs_dst_t'(i_dst))
			crs_pkg::CRS_DST_INDEX: alu_a = idx_q;
			crs_pkg::CRS_DST_SP: alu_a = sp_q;
			crs_pkg::CRS_DST_FLAGS: alu_a = flags_q;
			default: alu_a = acc_q;
		endcase
	end

	// indexed mode: operand plus index register
	assign o_indexed_addr = i_operand + idx_q;
	// with i_operand_is_index the second alu operand is the index register itself, not i_operand
	assign alu_b = i_operand_is_index ? idx_q : i_operand;
	// swap exchanges the accumulator with an index or stack pointer target
	assign swap_partner = acc_q;

	crs_alu u_alu (
		.i_op(i_op),
		.i_a(alu_a),
		.i_b(alu_b),
		.i_carry(flags_q[crs_pkg::CRS_FLAG_CARRY]),
		.o_result(alu_res),
		.o_carry(alu_carry),
		.o_carry_valid(alu_carry_valid)
	);

	// ***********************************************
	// program counter
	// ***********************************************
	// a 16-bit wrap is harmless: all of program memory sits below it
	assign pc_seq = pc_q + {14'h0000, i_pc_step};

	always_comb begin
		pc_d = pc_q;
		if (i_pc_load) begin
			pc_d = i_pc_target;
		end else if (i_pc_inc) begin
			pc_d = pc_seq;
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			pc_q <= crs_pkg::CRS_PC_RESET;
		end else if (i_clk_en) begin
			pc_q <= pc_d;
		end
	end

	// ***********************************************
	// accumulator and index
	// ***********************************************
	always_comb begin
		acc_d = acc_q;
		if (dst_acc && !is_swap) begin
			acc_d = alu_res;
		end else if (is_swap && (dst_idx || dst_sp)) begin
			acc_d = dst_idx ? idx_q : sp_q;
		end
	end

	always_comb begin
		idx_d = idx_q;
		if (dst_idx) begin
			idx_d = is_swap ? swap_partner : alu_res;
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			acc_q <= crs_pkg::CRS_ZERO_BYTE;
		end else if (i_clk_en) begin
			acc_q <= acc_d;
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			idx_q <= crs_pkg::CRS_ZERO_BYTE;
		end else if (i_clk_en) begin
			idx_q <= idx_d;
		end
	end

	// ***********************************************
	// stack pointer
	// ***********************************************
	always_comb begin
		sp_d = sp_q;
		// no overflow check: the stack wraps inside its 256-byte page
		case (crs_pkg::crs_spop_t'(i_sp_op))
			crs_pkg::CRS_SP_PUSH1: sp_d = sp_q + 8'h01;
			crs_pkg::CRS_SP_POP1: sp_d = sp_q - 8'h01;
			crs_pkg::CRS_SP_PUSH2: sp_d = sp_q + 8'h02;
			crs_pkg::CRS_SP_POP2: sp_d = sp_q - 8'h02;
			crs_pkg::CRS_SP_POP3: sp_d = sp_q - 8'h03;
			default: sp_d = sp_q;
		endcase
		// an explicit write by swap or add outranks the stack action
		if (dst_sp) begin
			sp_d = is_swap ? swap_partner : alu_res;
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			sp_q <= crs_pkg::CRS_ZERO_BYTE;
		end else if (i_clk_en) begin
			sp_q <= sp_d;
		end
	end

	// ***********************************************
	// software write of the flags, bit by bit
	// ***********************************************
	// a bit outside the user mask keeps its value, which shields the super bit
	for (genvar b = 0; b < 8; b++) begin : g_flag_bit
		if (crs_pkg::CRS_FLAGS_USER_MASK[b]) begin : g_user
			assign flags_sw[b] = alu_res[b];
		end else begin : g_kept
			assign flags_sw[b] = flags_q[b];
		end
	end

	// ***********************************************
	// flags
	// ***********************************************
	always_comb begin
		flags_d = flags_q;
		if (flags_logic_wr) begin
			flags_d = flags_sw;
		end else if (i_exec && i_set_flags && !dst_flags && !is_swap) begin
			flags_d[crs_pkg::CRS_FLAG_ZERO] = (alu_res == 8'h00);
			if (alu_carry_valid) begin
				flags_d[crs_pkg::CRS_FLAG_CARRY] = alu_carry;
			end
		end
		if (i_int_entry) begin
			flags_d[crs_pkg::CRS_FLAG_GIE] = 1'b0;
		end
		if (i_super_enter) begin
			flags_d[crs_pkg::CRS_FLAG_SUPER] = 1'b1;
		end else if (i_super_leave) begin
			flags_d[crs_pkg::CRS_FLAG_SUPER] = 1'b0;
		end
		// reserved bits never hold a one
		flags_d = flags_d & crs_pkg::CRS_FLAGS_IMPL_MASK;
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			flags_q <= crs_pkg::CRS_FLAGS_RESET;
		end else if (i_clk_en) begin
			flags_q <= flags_d;
		end
	end

	// ***********************************************
	// register-space read of the flags
	// ***********************************************
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			rd_hit_q <= 1'b0;
		end else if (i_clk_en) begin
			rd_hit_q <= rd_match;
		end
	end

	// a miss returns zero rather than holding the last value, so nothing leaks
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			rd_data_q <= crs_pkg::CRS_ZERO_BYTE;
		end else if (i_clk_en) begin
			// only the flags answer; other core registers are not in register space
			if (rd_match) begin
				rd_data_q <= flags_q;
			end else begin
				rd_data_q <= crs_pkg::CRS_ZERO_BYTE;
			end
		end
	end

	// ***********************************************
	// outputs
	// ***********************************************
	assign o_rd_data = rd_data_q;
	assign o_rd_hit = rd_hit_q;
	assign o_program_counter = pc_q;
	assign o_program_counter_low = pc_q[7:0];
	assign o_program_counter_high = pc_q[15:8];
	assign o_accumulator = acc_q;
	assign o_index = idx_q;
	assign o_stack_pointer = sp_q;
	assign o_processor_flags = flags_q;
	assign o_global_interrupt_enable = flags_q[crs_pkg::CRS_FLAG_GIE];
	assign o_bank_select = flags_q[crs_pkg::CRS_FLAG_BANK];
	assign o_supervisor = flags_q[crs_pkg::CRS_FLAG_SUPER];

endmodule : crs_core_regs

// ==== verification/crs_core_regs_properties.sv ====
// checker: timing properties of the core register set
module crs_core_regs_chk (
	input wire logic i_sys_clk, i_rst, i_clk_en, i_exec, i_operand_is_index,
	input wire logic i_pc_load, i_pc_inc, i_super_enter, i_super_leave, i_int_entry,
	input wire logic i_rd_en, o_rd_hit, o_global_interrupt_enable, o_bank_select, o_supervisor,
	input wire logic [3:0] i_op,
	input wire logic [2:0] i_dst, i_sp_op,
	input wire logic [1:0] i_pc_step,
	input wire logic [15:0] o_program_counter,
	input wire logic [7:0] i_operand, i_rd_addr, o_rd_data, o_accumulator, o_index,
	input wire logic [7:0] o_stack_pointer, o_processor_flags, o_indexed_addr
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	// ***
	// properties
	// ***
	chk_rd_hit: assert property (i_clk_en && i_rd_en && i_rd_addr == 8'hf7
		|=> o_rd_hit && o_rd_data == $past(o_processor_flags)) else $error("flags read wrong");
	chk_rd_miss: assert property (i_clk_en && i_rd_en && i_rd_addr != 8'hf7
		|=> !o_rd_hit && o_rd_data == 8'h00) else $error("unmapped read answered");
	chk_super_hold: assert property (!i_super_enter && !i_super_leave
		|=> $stable(o_processor_flags[3])) else $error("supervisory bit moved");
	chk_flag_views: assert property ({o_bank_select, o_supervisor} ==
		o_processor_flags[4:3] && o_global_interrupt_enable == o_processor_flags[0])
		else $error("flag views differ");
	chk_pc_step: assert property (i_clk_en && !i_pc_load && i_pc_inc
		|=> o_program_counter == $past(o_program_counter) + $past(i_pc_step))
		else $error("pc step wrong");
	chk_sp_push: assert property (i_clk_en && i_sp_op == 3'h1
		&& !(i_exec && i_dst == 3'h3) |=> o_stack_pointer == $past(o_stack_pointer) + 8'h01)
		else $error("push step wrong");
	chk_acc_add: assert property (i_clk_en && i_exec && i_op == 4'h1 && i_dst == 3'h1
		&& !i_operand_is_index |=> o_accumulator == $past(o_accumulator) + $past(i_operand))
		else $error("add result wrong");
	chk_index_addr: assert property (o_indexed_addr == i_operand + o_index)
		else $error("indexed address wrong");
	chk_int_clear: assert property (i_clk_en && i_int_entry
		|=> !o_global_interrupt_enable) else $error("interrupt entry kept enable");
	chk_freeze: assert property (!i_clk_en
		|=> $stable(o_accumulator) && $stable(o_processor_flags)) else $error("moved while held");
	cover property (i_clk_en && i_exec && i_op == 4'ha && i_dst == 3'h3);
	cover property (i_clk_en && i_rd_en && i_rd_addr == 8'hf7);
	cover property (i_clk_en && i_exec && i_op == 4'ha);
	cover property (i_clk_en && i_exec && i_dst == 3'h4);
endmodule : crs_core_regs_chk

bind crs_core_regs crs_core_regs_chk u_chk (.i_sys_clk, .i_rst, .i_clk_en, .i_exec,
	.i_operand_is_index, .i_pc_load, .i_pc_inc, .i_super_enter, .i_super_leave, .i_int_entry,
	.i_rd_en, .o_rd_hit, .o_global_interrupt_enable, .o_bank_select, .o_supervisor, .i_op,
	.i_dst, .i_sp_op, .i_pc_step, .o_program_counter, .i_operand, .i_rd_addr, .o_rd_data,
	.o_accumulator, .o_index, .o_stack_pointer, .o_processor_flags, .o_indexed_addr);

// ==== verification/tb_top.sv ====
// testbench: random instruction stream checked against a reference model
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_sys_clk = 0, i_rst = 1, i_clk_en = 0, i_exec = 0, i_operand_is_index = 0;
	logic i_set_flags = 0, i_pc_load = 0, i_pc_inc = 0, i_super_enter = 0;
	logic i_super_leave = 0, i_int_entry = 0, i_rd_en = 0, o_rd_hit;
	logic o_global_interrupt_enable, o_bank_select, o_supervisor;
	logic [3:0] i_op = 4'h0;
	logic [2:0] i_dst = 3'h0, i_sp_op = 3'h0;
	logic [1:0] i_pc_step = 2'h0;
	logic [15:0] i_pc_target = 16'h0000, o_program_counter;
	logic [7:0] i_operand = 8'h00, i_rd_addr = 8'h00, o_rd_data, o_program_counter_low;
	logic [7:0] o_program_counter_high, o_accumulator, o_index, o_stack_pointer;
	logic [7:0] o_processor_flags, o_indexed_addr;
	int a, x, s, f, pc, rd, hit, cyc, n_fail, n_tests, seed = 39;
	int sd[6] = '{0, 1, -1, 2, -2, -3};

	crs_core_regs i_crs_core_regs (.i_sys_clk, .i_rst, .i_clk_en, .i_exec, .i_op, .i_dst,
		.i_operand, .i_operand_is_index, .i_set_flags, .i_pc_load, .i_pc_target, .i_pc_inc,
		.i_pc_step, .i_sp_op, .i_super_enter, .i_super_leave, .i_int_entry, .i_rd_en,
		.i_rd_addr, .o_rd_data, .o_rd_hit, .o_program_counter, .o_program_counter_low,
		.o_program_counter_high, .o_accumulator, .o_index, .o_stack_pointer,
		.o_processor_flags, .o_indexed_addr, .o_global_interrupt_enable, .o_bank_select,
		.o_supervisor);

	// ***
	// model and checks
	// ***
	task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic final_report();
		if (n_fail == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : final_report

	task automatic reset_model();
		a = 0;
		x = 0;
		s = 0;
		f = 2;
		pc = 0;
		rd = 0;
		hit = 0;
	endtask : reset_model

	task automatic drive();
		i_clk_en = ($random(seed) & 15) != 0;
		{i_exec, i_operand_is_index, i_set_flags, i_pc_load, i_pc_inc, i_rd_en} = 6'($random(seed));
		i_op = 4'({$random(seed)} % 11);
		i_dst = 3'({$random(seed)} % 5);
		// only add and swap may target the stack pointer
		if (i_dst == 3'h3 && i_op != 4'ha) i_op = 4'h1;
		i_sp_op = 3'({$random(seed)} % 6);
		{i_operand, i_pc_target, i_pc_step} = 26'($random(seed));
		{i_super_enter, i_super_leave, i_int_entry} = 3'($random(seed) & $random(seed));
		i_rd_addr = ($random(seed) & 1) ? 8'hf7 : 8'($random(seed));
	endtask : drive

	task automatic step();
		int b, r, c, d;
		if (!i_clk_en) return;
		hit = i_rd_en && i_rd_addr == 8'hf7;
		rd = hit ? f : 0;
		b = i_operand_is_index ? x : i_operand;
		d = (i_dst == 3'h2) ? x : (i_dst == 3'h3) ? s : (i_dst == 3'h4) ? f : a;
		c = (f >> 2) & 1;
		// carry out lands in bit 8 for every op that sets it
		case (i_op)
			4'h0: r = d;
			4'h1: r = d + b;
			4'h2: r = d + b + c;
			4'h3: r = d - b;
			4'h4: r = d & b;
			4'h5: r = d | b;
			4'h6: r = d ^ b;
			4'h7: r = d << 1;
			4'h8: r = (d >> 1) | ((d & 1) << 8);
			default: r = b;
		endcase
		if (i_exec && i_set_flags && i_dst != 3'h4 && i_op != 4'ha) begin
			f = (f & 'hfd) | (((r & 'hff) == 0) << 1);
			if (i_op inside {1, 2, 3, 7, 8}) f = (f & 'hfb) | (((r >> 8) & 1) << 2);
		end
		if (!(i_exec && i_dst == 3'h3)) s = (s + sd[i_sp_op]) & 'hff;
		if (i_exec && i_op == 4'ha && i_dst inside {2, 3}) begin
			if (i_dst == 3'h2) x = a;
			else s = a;
			a = d;
		end else if (i_exec && i_op != 4'ha) begin
			case (i_dst)
				3'h1: a = r & 'hff;
				3'h2: x = r & 'hff;
				3'h3: s = r & 'hff;
				3'h4: f = (i_op == 4'h4) ? f & (b | 'he8) : (i_op == 4'h5) ? f | (b & 'h17) : f;
				default: ;
			endcase
		end
		if (i_pc_load) pc = i_pc_target;
		else if (i_pc_inc) pc = (pc + i_pc_step) & 'hffff;
		if (i_int_entry) f = f & 'hfe;
		if (i_super_enter) f = f | 8;
		else if (i_super_leave) f = f & 'hf7;
	endtask : step

	task automatic compare();
		check("acc", 16'(o_accumulator), 16'(a));
		check("index", 16'(o_index), 16'(x));
		check("sp", 16'(o_stack_pointer), 16'(s));
		check("flags", 16'(o_processor_flags), 16'(f));
		check("pc", o_program_counter, 16'(pc));
		check("pc bytes", {o_program_counter_high, o_program_counter_low}, 16'(pc));
		check("read", {7'h0, o_rd_hit, o_rd_data}, 16'(hit * 256 + rd));
		check("views", {11'h0, o_bank_select, o_supervisor, 2'h0,
			o_global_interrupt_enable}, 16'(f & 'h19));
		check("ixaddr", 16'(o_indexed_addr), 16'((i_operand + x) & 'hff));
	endtask : compare

	// ***
	// clock, timeout and sequence
	// ***
	initial begin
		forever #10 i_sys_clk = ~i_sys_clk;
	end

	always @(posedge i_sys_clk) begin
		cyc++;
		if (cyc > 4000) begin
			n_fail++;
			final_report();
		end
	end

	initial begin
		reset_model();
		repeat (6) @(posedge i_sys_clk);
		// one reset mid-run to check recovery from a live state
		for (int k = 0; k < 3000; k++) begin
			@(negedge i_sys_clk);
			i_rst = k == 1500;
			if (i_rst) reset_model();
			else begin
				drive();
				#1 compare();
				step();
			end
		end
		final_report();
	end
endmodule : tb_top
